// [design/ulms_consts.vh]
// Constants for the channel status and auxiliary register block
`ifndef ULMS_CONSTS_VH
`define ULMS_CONSTS_VH

// Register addresses on the three-bit channel address
`define ULMS_ADDR_DATA 3'h0
`define ULMS_ADDR_LSR 3'h5
`define ULMS_ADDR_MSR 3'h6
`define ULMS_ADDR_SPR 3'h7

// Reset values
`define ULMS_SPR_RST 8'hFF
`define ULMS_CMS_RST 8'h00
`define ULMS_ZERO8 8'h00

// Control bit positions in the loose control inputs
`define ULMS_IER_MSI 3
`define ULMS_EFR_ACTS 7
`define ULMS_FEATURE_CONTROL_SWAP 6
`define ULMS_MCR_LOOP 4
`define ULMS_MCR_DTR 0
`define ULMS_MCR_RTS 1
`define ULMS_MCR_OP1 2
`define ULMS_MCR_OP2 3

// Count mode encodings, count_mode_select bits 1:0
`define ULMS_CM_TX 2'h1
`define ULMS_CM_ALT 2'h3

// Modem vector positions: cts, dsr, ri, cd
`define ULMS_M_CTS 0
`define ULMS_M_DSR 1
`define ULMS_M_RI 2
`define ULMS_M_CD 3

// Receive entry layout: data then parity, framing, break flags
`define ULMS_E_PE 8
`define ULMS_E_FE 9
`define ULMS_E_BRK 10

// Field slices: count mode, hysteresis codes, data byte, pins
`define ULMS_CMS_MODE 1:0
`define ULMS_CMS_HYS 5:4
`define ULMS_FEATURE_CONTROL_HYS 1:0
`define ULMS_RXD 7:0
`define ULMS_M_ALL 3:0
`define ULMS_PIN_RX 4

// Hysteresis in characters, six bits each, code 15 down to code 0
`define ULMS_HYS_W 6
`define ULMS_HYST_TBL {6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, \
    6'h28, 6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00}

`endif

// [design/ulms_status.v]
// Line status, modem status, scratch and fifo level logic of one channel
//
// Behaviour
// - Full receive fifo drops new character, flags overrun
// - Parity flag follows character at fifo head
// - Framing flag follows character at fifo head
// - Long low line flags break, stores one
// - Break indication held until line idles high
// - Holding empty flag tracks empty transmit fifo
// - Transmitter idle when fifo and shifter empty
// - Global flag while any stored character errs
// - Cts, dsr, cd changes set sticky bits
// - Ring change bit sets only on rising pin, or on falling op1 in loopback
// - Change bits plus enable request modem interrupt
// - Auto cts high halts after current character
// - Normal mode status bits show inverted pins
// - Loopback status bits show modem control bits
// - Scratch register kept, resets to all ones
// - Swap bit redirects scratch writes and reads
// - Mode bits choose receive, transmit or alternate
// - Alternate mode starts receive, then alternates
// - Four-bit code picks hysteresis character count
// - Level register returns selected fifo count
// - Modem control bit four enables loopback
// - Data ready while receive fifo not empty
`timescale 1ns/10ps
`include "ulms_consts.vh"

module ulms_status #(
    parameter AW = 4
) (
    // Clock, reset, enable
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    // Host register port, one-cycle strobes
    input wire [2:0] addr_i,
    input wire rd_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    // Control bits held elsewhere in the channel
    input wire fifo_en_i,
    input wire [7:0] modem_control_i,
    input wire [7:0] interrupt_enable_i,
    input wire [7:0] feature_control_i,
    input wire [7:0] enhanced_feature_i,
    // Receiver side
    input wire rx_pin_i,
    input wire rx_char_i,
    input wire [7:0] rx_data_i,
    input wire rx_pe_i,
    input wire rx_fe_i,
    input wire rx_brk_i,
    // Transmitter side
    input wire tx_take_i,
    input wire tx_shift_busy_i,
    output reg tx_valid_o,
    output reg [7:0] tx_data_o,
    output reg tx_halt_o,
    // Modem pins, active low
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire ri_n_i,
    input wire cd_n_i,
    // Results
    output reg msi_req_o,
    output reg [5:0] rts_hyst_o
);

localparam DEPTH = 1 << AW;
localparam [AW:0] CAP_FULL = DEPTH;
localparam [AW:0] CAP_ONE = 1;
localparam [AW:0] CNT_ZERO = 0;

////////////////////////////////////////////////////////////////////////
// Access decode
wire rd_data = ce_i & rd_i & (addr_i == `ULMS_ADDR_DATA);
wire wr_data = ce_i & wr_i & (addr_i == `ULMS_ADDR_DATA);
wire rd_lsr = ce_i & rd_i & (addr_i == `ULMS_ADDR_LSR);
wire rd_msr = ce_i & rd_i & (addr_i == `ULMS_ADDR_MSR);
wire rd_spr = ce_i & rd_i & (addr_i == `ULMS_ADDR_SPR);
wire wr_spr = ce_i & wr_i & (addr_i == `ULMS_ADDR_SPR);
wire swap = feature_control_i[`ULMS_FEATURE_CONTROL_SWAP];
// Non-fifo mode behaves as a one-entry fifo
wire [AW:0] cap = fifo_en_i ? CAP_FULL : CAP_ONE;

////////////////////////////////////////////////////////////////////////
// Three-stage synchronisers for receive line and modem pins
reg [4:0] sync1_q;
reg [4:0] sync2_q;
reg [4:0] sync3_q;
reg [4:0] pin_q;
wire [4:0] pins = {rx_pin_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i};

// A level is taken only once stages two and three agree
genvar g;
generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_sync
        always @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                sync1_q[g] <= 1'b1;
                sync2_q[g] <= 1'b1;
                sync3_q[g] <= 1'b1;
                pin_q[g] <= 1'b1;
            end
            else if (ce_i)
            begin
                sync1_q[g] <= pins[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g])
                    pin_q[g] <= sync3_q[g];
            end
        end
    end
endgenerate

wire rx_idle = pin_q[`ULMS_PIN_RX];

////////////////////////////////////////////////////////////////////////
// Receive fifo with per-byte error flags
reg [10:0] rx_mem [0:DEPTH-1];
reg [AW-1:0] rx_wp_q;
reg [AW-1:0] rx_rp_q;
reg [AW:0] rx_cnt_q;
reg [AW:0] err_cnt_q;
reg brk_hold_q;
reg overrun_q;

wire rx_empty = (rx_cnt_q == CNT_ZERO);
wire [10:0] rx_head = rx_mem[rx_rp_q];
wire head_err = ~rx_empty & (|rx_head[`ULMS_E_BRK:`ULMS_E_PE]);
// Further break characters are dropped while the line stays low
wire rx_take = rx_char_i & ~(rx_brk_i & brk_hold_q);
wire rx_full = (rx_cnt_q >= cap);
wire rx_push = ce_i & rx_take & ~rx_full;
wire rx_ovr = ce_i & rx_take & rx_full;
wire rx_pop = rd_data & ~rx_empty;
wire in_err = rx_pe_i | rx_fe_i | rx_brk_i;

// Storage; a dropped character never touches the fifo
always @(posedge clk_i)
begin
    if (rx_push)
        rx_mem[rx_wp_q] <= {rx_brk_i, rx_fe_i, rx_pe_i, rx_data_i};
end

// Pointers, counts and sticky receive flags
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        rx_wp_q <= {AW{1'b0}};
        rx_rp_q <= {AW{1'b0}};
        rx_cnt_q <= CNT_ZERO;
        err_cnt_q <= CNT_ZERO;
        brk_hold_q <= 1'b0;
        overrun_q <= 1'b0;
    end
    else if (ce_i)
    begin
        if (rx_push)
            rx_wp_q <= rx_wp_q + 1'b1;
        if (rx_pop)
            rx_rp_q <= rx_rp_q + 1'b1;
        if (rx_push & ~rx_pop)
            rx_cnt_q <= rx_cnt_q + 1'b1;
        else if (rx_pop & ~rx_push)
            rx_cnt_q <= rx_cnt_q - 1'b1;
        if ((rx_push & in_err) & ~(rx_pop & head_err))
            err_cnt_q <= err_cnt_q + 1'b1;
        else if ((rx_pop & head_err) & ~(rx_push & in_err))
            err_cnt_q <= err_cnt_q - 1'b1;
        // Set wins over the idle-line clear
        if (rx_push & rx_brk_i)
            brk_hold_q <= 1'b1;
        else if (rx_idle)
            brk_hold_q <= 1'b0;
        // Set wins over the clear by reading line status
        if (rx_ovr)
            overrun_q <= 1'b1;
        else if (rd_lsr)
            overrun_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Transmit fifo feeding the shifter
reg [7:0] tx_mem [0:DEPTH-1];
reg [AW-1:0] tx_wp_q;
reg [AW-1:0] tx_rp_q;
reg [AW:0] tx_cnt_q;

wire tx_push = wr_data & (tx_cnt_q < cap);
wire tx_pop = ce_i & tx_take_i & tx_valid_o;
wire [AW-1:0] tx_rp_d = tx_pop ? tx_rp_q + 1'b1 : tx_rp_q;
reg [AW:0] tx_cnt_d;
always @*
begin
    tx_cnt_d = tx_cnt_q;
    if (tx_push & ~tx_pop)
        tx_cnt_d = tx_cnt_q + 1'b1;
    else if (tx_pop & ~tx_push)
        tx_cnt_d = tx_cnt_q - 1'b1;
end
// Head byte bypasses the array when it is written this very cycle
wire [7:0] tx_head_d = (tx_push && tx_rp_d == tx_wp_q) ? wdata_i
                                                        : tx_mem[tx_rp_d];
// Auto cts only gates the start of a character, never cuts one short
wire halt_d = enhanced_feature_i[`ULMS_EFR_ACTS] & pin_q[`ULMS_M_CTS];

always @(posedge clk_i)
begin
    if (tx_push)
        tx_mem[tx_wp_q] <= wdata_i;
end

// Pointers and the registered shifter handshake
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        tx_wp_q <= {AW{1'b0}};
        tx_rp_q <= {AW{1'b0}};
        tx_cnt_q <= CNT_ZERO;
        tx_valid_o <= 1'b0;
        tx_data_o <= `ULMS_ZERO8;
        tx_halt_o <= 1'b0;
    end
    else if (ce_i)
    begin
        if (tx_push)
            tx_wp_q <= tx_wp_q + 1'b1;
        tx_rp_q <= tx_rp_d;
        tx_cnt_q <= tx_cnt_d;
        tx_valid_o <= (tx_cnt_d != CNT_ZERO) & ~halt_d;
        tx_data_o <= tx_head_d;
        tx_halt_o <= halt_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Line status assembly
wire thr_empty = (tx_cnt_q == CNT_ZERO);
wire tx_idle = thr_empty & ~tx_shift_busy_i;
wire [7:0] line_status = {
    err_cnt_q != CNT_ZERO,
    tx_idle,
    thr_empty,
    (~rx_empty & rx_head[`ULMS_E_BRK]) | brk_hold_q,
    ~rx_empty & rx_head[`ULMS_E_FE],
    ~rx_empty & rx_head[`ULMS_E_PE],
    overrun_q,
    ~rx_empty
};

////////////////////////////////////////////////////////////////////////
// Modem status: current levels and sticky change bits
reg [3:0] mst_q;
reg [3:0] delta_q;
wire loop = modem_control_i[`ULMS_MCR_LOOP];
// Loopback maps rts, dtr, op1, op2 onto cts, dsr, ri, cd
wire [3:0] mst_loop = {modem_control_i[`ULMS_MCR_OP2],
                       modem_control_i[`ULMS_MCR_OP1],
                       modem_control_i[`ULMS_MCR_DTR],
                       modem_control_i[`ULMS_MCR_RTS]};
wire [3:0] mst_d = loop ? mst_loop : ~pin_q[`ULMS_M_ALL];
wire [3:0] chg = mst_d ^ mst_q;
// Ring status falling means the ring input rose: end of ring
wire ri_end = mst_q[`ULMS_M_RI] & ~mst_d[`ULMS_M_RI];
wire [3:0] dset = {chg[`ULMS_M_CD], ri_end, chg[`ULMS_M_DSR],
                   chg[`ULMS_M_CTS]};

// A change in the read cycle survives the read
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        mst_q <= 4'h0;
        delta_q <= 4'h0;
        msi_req_o <= 1'b0;
    end
    else if (ce_i)
    begin
        mst_q <= mst_d;
        delta_q <= (rd_msr ? 4'h0 : delta_q) | dset;
        msi_req_o <= interrupt_enable_i[`ULMS_IER_MSI] &
                     (|((rd_msr ? 4'h0 : delta_q) | dset));
    end
end

////////////////////////////////////////////////////////////////////////
// Scratch, count mode select and fifo level
reg [7:0] spr_q;
reg [7:0] cms_q;
reg alt_q;
wire [1:0] cmode = cms_q[`ULMS_CMS_MODE];
wire lvl_tx = (cmode == `ULMS_CM_TX) |
              ((cmode == `ULMS_CM_ALT) & alt_q);
wire [7:0] rx_lvl = {{(7-AW){1'b0}}, rx_cnt_q};
wire [7:0] tx_lvl = {{(7-AW){1'b0}}, tx_cnt_q};
wire [7:0] fifo_fill_level = lvl_tx ? tx_lvl : rx_lvl;

// Scratch survives everything but reset; swap steers the address
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        spr_q <= `ULMS_SPR_RST;
        cms_q <= `ULMS_CMS_RST;
        alt_q <= 1'b0;
    end
    else if (ce_i)
    begin
        if (wr_spr & ~swap)
            spr_q <= wdata_i;
        if (wr_spr & swap)
        begin
            cms_q <= wdata_i;
            alt_q <= 1'b0;
        end
        else if (rd_spr & swap & (cmode == `ULMS_CM_ALT))
            alt_q <= ~alt_q;
    end
end

// Table lookup keeps the irregular upper codes in one place
localparam [16*`ULMS_HYS_W-1:0] HYST_TBL = `ULMS_HYST_TBL;
wire [3:0] hyst_code = {cms_q[`ULMS_CMS_HYS], feature_control_i[`ULMS_FEATURE_CONTROL_HYS]};

////////////////////////////////////////////////////////////////////////
// Read data mux, registered on the read strobe
reg [7:0] rd_mux;
always @*
begin
    case (addr_i)
        `ULMS_ADDR_DATA: rd_mux = rx_empty ? `ULMS_ZERO8 : rx_head[`ULMS_RXD];
        `ULMS_ADDR_LSR: rd_mux = line_status;
        `ULMS_ADDR_MSR: rd_mux = {mst_q[`ULMS_M_CD], mst_q[`ULMS_M_RI],
                                  mst_q[`ULMS_M_DSR], mst_q[`ULMS_M_CTS],
                                  delta_q};
        `ULMS_ADDR_SPR: rd_mux = swap ? fifo_fill_level : spr_q;
        default: rd_mux = `ULMS_ZERO8;
    endcase
end

// Other addresses belong to other blocks and read as zero here
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        rdata_o <= `ULMS_ZERO8;
        rts_hyst_o <= 6'd0;
    end
    else if (ce_i)
    begin
        if (rd_i)
            rdata_o <= rd_mux;
        rts_hyst_o <= HYST_TBL[hyst_code * `ULMS_HYS_W +: `ULMS_HYS_W];
    end
end

endmodule

// [sim/ulms_far.sv]
// Far-side transmit shifter model for the channel status block
`timescale 1ns/10ps
module ulms_far (
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Block transmit side
    input wire tx_valid_i,
    input wire [7:0] tx_data_i,
    output wire take_o,
    output wire busy_o
);
    reg [2:0] cnt_q;
    reg [3:0] n_q;
    reg [7:0] seen_q [0:7];
    // Takes only when idle, so a halt shows as bytes not arriving
    assign take_o = tx_valid_i && cnt_q == 3'h0;
    assign busy_o = cnt_q != 3'h0;
    // Shift time of five cycles and a log of the last eight bytes taken
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= 3'h0;
            n_q <= 4'h0;
        end
        else if (take_o)
        begin
            cnt_q <= 3'h5;
            seen_q[n_q[2:0]] <= tx_data_i;
            n_q <= n_q + 4'h1;
        end
        else if (busy_o)
            cnt_q <= cnt_q - 3'h1;
    end
endmodule

// [sim/ulms_status_chk.sv]
// Port assertions for the channel status block
`timescale 1ns/10ps
`include "ulms_consts.vh"
module ulms_status_chk (
    // Watched ports
    input wire clk_i,
    input wire nrst_i,
    input wire [2:0] addr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [7:0] modem_control_i,
    input wire [7:0] interrupt_enable_i,
    input wire [7:0] enhanced_feature_i,
    input wire tx_valid_o,
    input wire tx_halt_o,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire ri_n_i,
    input wire cd_n_i,
    input wire msi_req_o
);
    wire [11:0] mdm = {cts_n_i, dsr_n_i, ri_n_i, cd_n_i, modem_control_i};
    reg [11:0] mdm_q;
    reg [3:0] quiet_q;
    // Cycles with modem sources unchanged, saturating
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mdm_q <= 12'h000;
            quiet_q <= 4'h0;
        end
        else
        begin
            mdm_q <= mdm;
            if (mdm != mdm_q)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hf)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence msr_rd;
        rd_i && addr_i == `ULMS_ADDR_MSR;
    endsequence
    sequence lsr_rd;
        rd_i && addr_i == `ULMS_ADDR_LSR;
    endsequence
    a_msi_gate:
    assert property (!interrupt_enable_i[3] |=> !msi_req_o)
        else $error("modem request without enable");
    a_halt_blocks:
    assert property (tx_halt_o |-> !tx_valid_o)
        else $error("byte offered while halted");
    a_halt_off:
    assert property ((!enhanced_feature_i[7])[*6] |=> !tx_halt_o)
        else $error("halt with auto cts off");
    a_rdata_hold:
    assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    a_loop_map:
    assert property (($stable(modem_control_i)[*3] ##0 msr_rd
        ##0 modem_control_i[4]) |=> rdata_o[7:4] == $past({modem_control_i[3],
        modem_control_i[2], modem_control_i[0], modem_control_i[1]}))
        else $error("loopback status mismatch");
    a_idle_empty:
    assert property (lsr_rd |=> !rdata_o[6] || rdata_o[5])
        else $error("idle without holding empty");
    a_err_global:
    assert property (lsr_rd |=> !(rdata_o[2] | rdata_o[3])
        || (rdata_o[7] && rdata_o[0]))
        else $error("head error without global flag");
    a_delta_clear:
    assert property ((rd_i && addr_i == `ULMS_ADDR_MSR && quiet_q > 4'h8
        && $past(rd_i && addr_i == `ULMS_ADDR_MSR, 2)) |=> rdata_o[3:0] == 4'h0)
        else $error("change bits survived read");
endmodule
bind ulms_status ulms_status_chk chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .modem_control_i(modem_control_i), .interrupt_enable_i(interrupt_enable_i),
    .enhanced_feature_i(enhanced_feature_i), .tx_valid_o(tx_valid_o),
    .tx_halt_o(tx_halt_o), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
    .ri_n_i(ri_n_i), .cd_n_i(cd_n_i), .msi_req_o(msi_req_o));

// [sim/tb_ulms_status.sv]
// Self-checking testbench for the channel status block
`timescale 1ns/10ps
`include "ulms_consts.vh"
module tb_ulms_status;
    reg clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg rd_i = 1'b0;
    reg wr_i = 1'b0;
    reg [2:0] addr_i = 3'h0;
    reg [7:0] wdata_i = 8'h00;
    reg rx_char_i = 1'b0;
    reg rx_pin_i = 1'b1;
    reg [10:0] rx_ent = 11'h000;
    reg [7:0] mc = 8'h00;
    reg [7:0] ie = 8'h00;
    reg [7:0] fc = 8'h00;
    reg [7:0] enhanced_feature = 8'h00;
    reg [3:0] pins_n = 4'hf;
    reg fe = 1'b1;
    wire [7:0] rdata_o;
    wire [7:0] tx_data_o;
    wire [5:0] rts_hyst_o;
    wire tx_valid_o, tx_halt_o, msi_req_o, take, busy;
    integer n_errors = 0;
    integer checked = 0;
    integer i;
    // Hysteresis in characters, code 15 down to code 0
    localparam [95:0] HT = {6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c,
        6'h28, 6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};
    always #20 clk_i = ~clk_i;
    ulms_status dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .fifo_en_i(fe), .modem_control_i(mc),
        .interrupt_enable_i(ie), .feature_control_i(fc),
        .enhanced_feature_i(enhanced_feature), .rx_pin_i(rx_pin_i), .rx_char_i(rx_char_i),
        .rx_data_i(rx_ent[7:0]), .rx_pe_i(rx_ent[8]), .rx_fe_i(rx_ent[9]),
        .rx_brk_i(rx_ent[10]), .tx_take_i(take), .tx_shift_busy_i(busy),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_halt_o(tx_halt_o),
        .cts_n_i(pins_n[0]), .dsr_n_i(pins_n[1]), .ri_n_i(pins_n[2]),
        .cd_n_i(pins_n[3]), .msi_req_o(msi_req_o), .rts_hyst_o(rts_hyst_o));
    ulms_far far (.clk_i(clk_i), .nrst_i(nrst_i), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .take_o(take), .busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    // Shared compare, bus cycles and receive push
    task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task wr(input [2:0] a, input [7:0] d);
    begin
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    end
    endtask
    task rdc(input [2:0] a, input [7:0] e, input string nm);
    begin
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(nm, e, rdata_o);
    end
    endtask
    task push(input [10:0] ent);
    begin
        @(posedge clk_i);
        rx_ent <= ent;
        rx_char_i <= 1'b1;
        @(posedge clk_i);
        rx_char_i <= 1'b0;
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk_i);
        #1;
    end
    endtask
    task summarize;
    begin
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
    begin
        rdc(`ULMS_ADDR_SPR, 8'hff, "scratch");
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
        rdc(`ULMS_ADDR_MSR, 8'h00, "msr");
    end
    endtask
    task t_scratch;
    begin
        wr(`ULMS_ADDR_SPR, 8'h5a);
        rdc(`ULMS_ADDR_SPR, 8'h5a, "scratch");
        @(posedge clk_i) fc <= 8'h40;
        wr(`ULMS_ADDR_SPR, 8'h00);
        rdc(`ULMS_ADDR_SPR, 8'h00, "level");
        @(posedge clk_i) fc <= 8'h00;
        rdc(`ULMS_ADDR_SPR, 8'h5a, "scratch");
    end
    endtask
    task t_rx;
    begin
        push(11'h1a1);
        push(11'h2b2);
        rdc(`ULMS_ADDR_LSR, 8'he5, "lsr");
        rdc(`ULMS_ADDR_DATA, 8'ha1, "data");
        rdc(`ULMS_ADDR_LSR, 8'he9, "lsr");
        rdc(`ULMS_ADDR_DATA, 8'hb2, "data");
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
        for (i = 0; i < 17; i = i + 1)
            push(i[10:0]);
        rdc(`ULMS_ADDR_LSR, 8'h63, "lsr");
        rdc(`ULMS_ADDR_LSR, 8'h61, "lsr");
        @(posedge clk_i) fc <= 8'h40;
        wr(`ULMS_ADDR_SPR, 8'h03);
        rdc(`ULMS_ADDR_SPR, 8'h10, "level");
        rdc(`ULMS_ADDR_SPR, 8'h00, "level");
        rdc(`ULMS_ADDR_SPR, 8'h10, "level");
        wr(`ULMS_ADDR_SPR, 8'h01);
        rdc(`ULMS_ADDR_SPR, 8'h00, "level");
        wr(`ULMS_ADDR_SPR, 8'h02);
        rdc(`ULMS_ADDR_SPR, 8'h10, "level");
        @(posedge clk_i) fc <= 8'h00;
        for (i = 0; i < 16; i = i + 1)
            rdc(`ULMS_ADDR_DATA, i[7:0], "data");
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
    end
    endtask
    task t_break;
    begin
        @(posedge clk_i) rx_pin_i <= 1'b0;
        // Line must be seen low before the break character completes
        wt(6);
        push(11'h400);
        push(11'h400);
        rdc(`ULMS_ADDR_LSR, 8'hf1, "lsr");
        rdc(`ULMS_ADDR_DATA, 8'h00, "data");
        rdc(`ULMS_ADDR_LSR, 8'h70, "lsr");
        @(posedge clk_i) rx_pin_i <= 1'b1;
        wt(6);
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
    end
    endtask
    // One-entry receive path: second character overruns
    task t_nofifo;
    begin
        @(posedge clk_i) fe <= 1'b0;
        push(11'h055);
        push(11'h066);
        rdc(`ULMS_ADDR_LSR, 8'h63, "lsr");
        rdc(`ULMS_ADDR_DATA, 8'h55, "data");
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
        @(posedge clk_i) fe <= 1'b1;
    end
    endtask
    task t_tx;
    begin
        wr(`ULMS_ADDR_DATA, 8'hc3);
        wr(`ULMS_ADDR_DATA, 8'h3c);
        wt(20);
        chk("first", 8'hc3, far.seen_q[0]);
        chk("second", 8'h3c, far.seen_q[1]);
        rdc(`ULMS_ADDR_LSR, 8'h60, "lsr");
        @(posedge clk_i) enhanced_feature <= 8'h80;
        wt(6);
        chk("halt", 8'h01, {7'h00, tx_halt_o});
        wr(`ULMS_ADDR_DATA, 8'h5a);
        wt(10);
        chk("count", 8'h02, {4'h0, far.n_q});
        rdc(`ULMS_ADDR_LSR, 8'h00, "lsr");
        @(posedge clk_i) pins_n[0] <= 1'b0;
        wt(20);
        chk("resumed", 8'h5a, far.seen_q[2]);
        chk("halt", 8'h00, {7'h00, tx_halt_o});
        @(posedge clk_i) enhanced_feature <= 8'h00;
    end
    endtask
    task t_modem;
    begin
        @(posedge clk_i) ie <= 8'h08;
        wt(2);
        chk("msi", 8'h01, {7'h00, msi_req_o});
        rdc(`ULMS_ADDR_MSR, 8'h11, "msr");
        wt(2);
        chk("msi", 8'h00, {7'h00, msi_req_o});
        @(posedge clk_i) pins_n[2] <= 1'b0;
        wt(6);
        rdc(`ULMS_ADDR_MSR, 8'h50, "msr");
        @(posedge clk_i) pins_n[2] <= 1'b1;
        wt(6);
        rdc(`ULMS_ADDR_MSR, 8'h14, "msr");
        @(posedge clk_i) pins_n <= 4'h4;
        wt(8);
        rdc(`ULMS_ADDR_MSR, 8'hba, "msr");
        rdc(`ULMS_ADDR_MSR, 8'hb0, "msr");
        @(posedge clk_i) mc <= 8'h15;
        wt(8);
        rdc(`ULMS_ADDR_MSR, 8'h69, "msr");
        @(posedge clk_i) mc <= 8'h1a;
        wt(8);
        rdc(`ULMS_ADDR_MSR, 8'h9f, "msr");
        @(posedge clk_i) mc <= 8'h00;
        ie <= 8'h00;
    end
    endtask
    task t_hyst;
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            @(posedge clk_i) fc <= {6'h10, i[1:0]};
            wr(`ULMS_ADDR_SPR, {2'h0, i[3:2], 4'h0});
            wt(3);
            chk("hyst", {2'h0, HT[i*6+:6]}, {2'h0, rts_hyst_o});
        end
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_scratch;
        t_rx;
        t_break;
        t_nofifo;
        t_tx;
        t_modem;
        t_hyst;
        summarize;
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_errors = n_errors + 1;
        summarize;
    end
endmodule
